// *** design/codec_port_consts.svh ***
`ifndef CODEC_PORT_CONSTS_SVH
`define CODEC_PORT_CONSTS_SVH

// Register byte addresses.
`define CPC_CTRL_ADDR 32'h8000_2000
`define CPC_EVT_STAT_ADDR 32'h8000_2004
`define CPC_EVT_CLR_ADDR 32'h8000_2008
`define CPC_EVT_EN_ADDR 32'h8000_200C
`define CPC_FLAG_STAT_ADDR 32'h8000_2010

// Control field positions.
`define CPC_AUD_DIV_LSB 0
`define CPC_AUD_DIV_MSB 6
`define CPC_TEL_DIV_LSB 8
`define CPC_TEL_DIV_MSB 14
`define CPC_EN_BIT 16
`define CPC_SPARE_BIT 17
`define CPC_MODE_BIT 18
`define CPC_TEL_TX_MASK_BIT 19
`define CPC_TEL_RX_MASK_BIT 20
`define CPC_AUD_TX_MASK_BIT 21
`define CPC_AUD_RX_MASK_BIT 22
`define CPC_LB_BIT 23

// Writable bits of the control word and its reset value.
`define CPC_CTRL_WMASK 32'h00FF_7F7F
`define CPC_CTRL_RESET 32'h0000_0000

// Capture event bits: 0 audio stored, 1 telecom stored,
// 2 audio timeout, 3 telecom timeout.
`define CPC_EVT_W 4
`define CPC_EVT_RESET 4'h0

// Fixed serial clock prescale ahead of the divisors.
`define CPC_PRESCALE 32
`define CPC_PRESCALE_W 5

`endif

// *** design/codec_port_pkg.sv ***
package codec_port_pkg;

	typedef enum logic [0:0] {
		CAP_VALID = 1'b0,
		CAP_TIMER = 1'b1
	} capture_mode_t;

	typedef enum logic [1:0] {
		RESP_OKAY = 2'b00,
		RESP_SLVERR = 2'b10
	} axi_resp_t;

endpackage

// *** design/codec_port_control.sv ***
// Function
// - Mode 0: store sample when valid set
// - Mode 1: first valid, then counter zeros
// - Eight sources, four maskable, four not
// - Interrupt is OR of masked and fixed sources
// - Telecom transmit mask gates its flag
// - Telecom receive mask gates its flag
// - Audio transmit mask gates its flag
// - Audio receive mask gates its flag
// - Masking leaves service flags untouched
// - Loopback 0: paths use own pins
// - Loopback 1: MSB to LSB, pins released
// - Reset clears enable; init others first
// - Reserved bits ignore writes, read zero
// - Rate counters reload divisor at zero
// - Audio divisor bits 6..0, 6 to 127
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
`include "codec_port_consts.svh"

module rate_timer #(
	parameter int DIV_W = 7
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic run_i,
	input wire logic step_i,
	input wire logic [DIV_W-1:0] divisor_i,
	output logic zero_o
);
	logic [DIV_W-1:0] count_ff;
	logic [DIV_W-1:0] nxt_count;
	wire hit = step_i && (count_ff <= 1);

	// Reload on reaching zero keeps the codec and port in lock-step.
	assign nxt_count = !run_i ? divisor_i :
		hit ? divisor_i :
		step_i ? count_ff - 1'b1 : count_ff;
	assign zero_o = run_i && hit;

	// Counter holds its reload value while the port is stopped.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			count_ff <= '0;
		end else begin
			count_ff <= nxt_count;
		end
	end
endmodule

module codec_port_control #(
	parameter int DATA_W = 16
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	// AXI4-Lite slave.
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output codec_port_pkg::axi_resp_t s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output codec_port_pkg::axi_resp_t s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Serial link pins.
	input wire logic serial_clock_pin_i,
	input wire logic serial_in_pin_i,
	output logic serial_out_pin_o,
	output logic serial_out_pin_oe_o,
	output logic pins_released_o,
	// Frame engine and shifter.
	input wire logic frame_done_i,
	input wire logic aud_valid_i,
	input wire logic tel_valid_i,
	input wire logic [DATA_W-1:0] aud_data_i,
	input wire logic [DATA_W-1:0] tel_data_i,
	input wire logic shifter_msb_i,
	output logic shifter_lsb_o,
	output logic aud_rx_push_o,
	output logic tel_rx_push_o,
	output logic [DATA_W-1:0] aud_rx_data_o,
	output logic [DATA_W-1:0] tel_rx_data_o,
	output logic port_enable_bit_o,
	output logic capture_mode_bit_o,
	output logic [6:0] audio_rate_divisor_o,
	output logic [6:0] telecom_rate_divisor_o,
	// FIFO service flags and extra sources.
	input wire logic tel_tx_service_flag_i,
	input wire logic tel_rx_service_flag_i,
	input wire logic aud_tx_service_flag_i,
	input wire logic aud_rx_service_flag_i,
	input wire logic [3:0] fixed_irq_src_i,
	output logic codec_irq_o,
	output logic capture_irq_o
);
	import codec_port_pkg::*;

	logic [31:0] ctrl_ff;
	logic [3:0] evt_stat_ff;
	logic [3:0] evt_en_ff;
	logic aw_held_ff;
	logic w_held_ff;
	logic [31:0] awaddr_ff;
	logic [31:0] wdata_ff;
	logic [3:0] wstrb_ff;
	logic bvalid_ff;
	axi_resp_t bresp_ff;
	logic rvalid_ff;
	axi_resp_t rresp_ff;
	logic [31:0] rdata_ff;
	logic [1:0] sclk_sync_ff;
	logic sclk_last_ff;
	logic [1:0] sin_sync_ff;
	logic [`CPC_PRESCALE_W-1:0] pre_ff;
	logic [1:0] armed_ff;
	logic [1:0] pend_ff;
	logic [1:0] push_ff;
	logic [DATA_W-1:0] aud_data_ff;
	logic [DATA_W-1:0] tel_data_ff;

	// Control fields.
	wire enable = ctrl_ff[`CPC_EN_BIT];
	wire mode_timer = ctrl_ff[`CPC_MODE_BIT] == CAP_TIMER;
	wire loopback = ctrl_ff[`CPC_LB_BIT];
	wire [6:0] aud_div = ctrl_ff[`CPC_AUD_DIV_MSB:`CPC_AUD_DIV_LSB];
	wire [6:0] tel_div = ctrl_ff[`CPC_TEL_DIV_MSB:`CPC_TEL_DIV_LSB];
	wire [3:0] imask =
		ctrl_ff[`CPC_AUD_RX_MASK_BIT:`CPC_TEL_TX_MASK_BIT];

	assign port_enable_bit_o = enable;
	assign capture_mode_bit_o = ctrl_ff[`CPC_MODE_BIT];
	assign audio_rate_divisor_o = aud_div;
	assign telecom_rate_divisor_o = tel_div;

	// Write decode: both halves must be held and no response pending.
	wire do_write = aw_held_ff && w_held_ff && !bvalid_ff;
	wire wr_ctrl = awaddr_ff == `CPC_CTRL_ADDR;
	wire wr_clr = awaddr_ff == `CPC_EVT_CLR_ADDR;
	wire wr_en = awaddr_ff == `CPC_EVT_EN_ADDR;
	wire wr_ro = awaddr_ff == `CPC_EVT_STAT_ADDR ||
		awaddr_ff == `CPC_FLAG_STAT_ADDR;
	wire wr_hit = wr_ctrl || wr_clr || wr_en || wr_ro;
	wire [31:0] bmask = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}},
		{8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
	wire [31:0] wbits = wdata_ff & bmask;
	wire [31:0] ctrl_wmask = bmask & `CPC_CTRL_WMASK;
	wire [31:0] nxt_ctrl = (ctrl_ff & ~ctrl_wmask) |
		(wdata_ff & ctrl_wmask);

	assign s_axi_awready = !aw_held_ff;
	assign s_axi_wready = !w_held_ff;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;

	// Address and data are latched separately so either may come first.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			aw_held_ff <= 1'b0;
			awaddr_ff <= 32'h0000_0000;
		end else if (s_axi_awvalid && !aw_held_ff) begin
			aw_held_ff <= 1'b1;
			awaddr_ff <= s_axi_awaddr;
		end else if (do_write) begin
			aw_held_ff <= 1'b0;
		end
	end

	// Write data holding stage.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			w_held_ff <= 1'b0;
			wdata_ff <= 32'h0000_0000;
			wstrb_ff <= 4'h0;
		end else if (s_axi_wvalid && !w_held_ff) begin
			w_held_ff <= 1'b1;
			wdata_ff <= s_axi_wdata;
			wstrb_ff <= s_axi_wstrb;
		end else if (do_write) begin
			w_held_ff <= 1'b0;
		end
	end

	// Write response; unmapped addresses answer with a slave error.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bvalid_ff <= 1'b0;
			bresp_ff <= RESP_OKAY;
		end else if (do_write) begin
			bvalid_ff <= 1'b1;
			bresp_ff <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_ff <= 1'b0;
		end
	end

	// Only the enable bit needs a known reset; the rest is zeroed too.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctrl_ff <= `CPC_CTRL_RESET;
		end else if (do_write && wr_ctrl) begin
			ctrl_ff <= nxt_ctrl;
		end
	end

	// Read decode.
	wire [31:0] flag_stat = {22'h00_0000, armed_ff, fixed_irq_src_i,
		aud_rx_service_flag_i, aud_tx_service_flag_i,
		tel_rx_service_flag_i, tel_tx_service_flag_i};
	wire rd_ctrl = s_axi_araddr == `CPC_CTRL_ADDR;
	wire rd_stat = s_axi_araddr == `CPC_EVT_STAT_ADDR;
	wire rd_en = s_axi_araddr == `CPC_EVT_EN_ADDR;
	wire rd_flag = s_axi_araddr == `CPC_FLAG_STAT_ADDR;
	wire rd_clr = s_axi_araddr == `CPC_EVT_CLR_ADDR;
	wire rd_hit = rd_ctrl || rd_stat || rd_en || rd_flag || rd_clr;
	wire [31:0] rd_mux = rd_ctrl ? ctrl_ff :
		rd_stat ? {28'h000_0000, evt_stat_ff} :
		rd_en ? {28'h000_0000, evt_en_ff} :
		rd_flag ? flag_stat : 32'h0000_0000;

	assign s_axi_arready = !rvalid_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;

	// Read answer one cycle after the address is taken.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h0000_0000;
			rresp_ff <= RESP_OKAY;
		end else if (s_axi_arvalid && !rvalid_ff) begin
			rvalid_ff <= 1'b1;
			rdata_ff <= rd_mux;
			rresp_ff <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_ff <= 1'b0;
		end
	end

	// Pin synchronisers; the first stage feeds only the second.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sclk_sync_ff <= 2'b00;
			sin_sync_ff <= 2'b00;
			sclk_last_ff <= 1'b0;
		end else begin
			sclk_sync_ff <= {sclk_sync_ff[0], serial_clock_pin_i};
			sin_sync_ff <= {sin_sync_ff[0], serial_in_pin_i};
			sclk_last_ff <= sclk_sync_ff[1];
		end
	end

	wire sclk_rise = sclk_sync_ff[1] && !sclk_last_ff;
	wire pre_wrap = sclk_rise &&
		(pre_ff == `CPC_PRESCALE_W'(`CPC_PRESCALE - 1));

	// Fixed divide by 32 of the serial clock, idle while disabled.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pre_ff <= '0;
		end else if (!enable) begin
			pre_ff <= '0;
		end else if (sclk_rise) begin
			pre_ff <= pre_wrap ? '0 : pre_ff + 1'b1;
		end
	end

	logic [1:0] timeout;

	rate_timer #(.DIV_W(7)) aud_timer (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .run_i(enable),
		.step_i(pre_wrap), .divisor_i(aud_div), .zero_o(timeout[0])
	);

	rate_timer #(.DIV_W(7)) tel_timer (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .run_i(enable),
		.step_i(pre_wrap), .divisor_i(tel_div), .zero_o(timeout[1])
	);

	// Index 0 is audio, index 1 is telecom.
	wire [1:0] valid = {tel_valid_i, aud_valid_i};
	wire [1:0] frame = {2{frame_done_i && enable}};
	wire [1:0] take_valid = frame & valid;
	// Each channel arms on its own; a shared arm would skip a sample.
	wire [1:0] take_timer = frame &
		((armed_ff & pend_ff) | (~armed_ff & valid));
	wire [1:0] take = mode_timer ? take_timer : take_valid;
	// A timeout in the storing cycle stays pending for the next frame.
	wire [1:0] nxt_pend = (pend_ff & ~take) | timeout;

	// Arm on the first valid frame after enable; pend on each timeout once armed.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			armed_ff <= 2'b00;
			pend_ff <= 2'b00;
		end else if (!enable) begin
			armed_ff <= 2'b00;
			pend_ff <= 2'b00;
		end else begin
			armed_ff <= armed_ff | (frame & valid);
			pend_ff <= armed_ff & nxt_pend;
		end
	end

	// Stored samples leave as registered pushes to the receive FIFOs.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			push_ff <= 2'b00;
			aud_data_ff <= '0;
			tel_data_ff <= '0;
		end else begin
			push_ff <= take;
			if (take[0]) aud_data_ff <= aud_data_i;
			if (take[1]) tel_data_ff <= tel_data_i;
		end
	end

	assign aud_rx_push_o = push_ff[0];
	assign tel_rx_push_o = push_ff[1];
	assign aud_rx_data_o = aud_data_ff;
	assign tel_rx_data_o = tel_data_ff;

	// Loopback wraps the shifter and hands the pins to the pin controller.
	assign shifter_lsb_o = loopback ? shifter_msb_i : sin_sync_ff[1];
	assign pins_released_o = loopback || !enable;
	assign serial_out_pin_o = shifter_msb_i;
	assign serial_out_pin_oe_o = enable && !loopback;

	// Masks gate only the request; flags pass through untouched.
	wire [3:0] svc = {aud_rx_service_flag_i, aud_tx_service_flag_i,
		tel_rx_service_flag_i, tel_tx_service_flag_i};
	wire tel_tx_req = svc[0] && imask[0];
	wire tel_rx_req = svc[1] && imask[1];
	wire aud_tx_req = svc[2] && imask[2];
	wire aud_rx_req = svc[3] && imask[3];
	assign codec_irq_o = tel_tx_req || tel_rx_req || aud_tx_req ||
		aud_rx_req || (|fixed_irq_src_i);

	// Capture events are sticky; a set in the clearing cycle wins.
	wire [3:0] evt_set = {timeout, take};
	wire [3:0] evt_clr = (do_write && wr_clr) ? wbits[3:0] : 4'h0;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			evt_stat_ff <= `CPC_EVT_RESET;
			evt_en_ff <= `CPC_EVT_RESET;
		end else begin
			evt_stat_ff <= (evt_stat_ff & ~evt_clr) | evt_set;
			if (do_write && wr_en && wstrb_ff[0]) evt_en_ff <= wdata_ff[3:0];
		end
	end

	assign capture_irq_o = |(evt_stat_ff & evt_en_ff);
endmodule

// *** sim/codec_port_properties.sv ***
`timescale 1ns/1ps

module codec_port_properties
	import codec_port_pkg::*;
#(
	parameter int DATA_W = 16
) (
	input logic clk_i,
	input logic rst_n_i,
	input logic s_axi_bvalid,
	input logic s_axi_bready,
	input axi_resp_t s_axi_bresp,
	input logic frame_done_i,
	input logic aud_valid_i,
	input logic tel_valid_i,
	input logic [DATA_W-1:0] aud_data_i,
	input logic port_enable_bit_o,
	input logic capture_mode_bit_o,
	input logic aud_rx_push_o,
	input logic tel_rx_push_o,
	input logic [DATA_W-1:0] aud_rx_data_o,
	input logic serial_out_pin_oe_o,
	input logic pins_released_o,
	input logic shifter_msb_i,
	input logic shifter_lsb_o,
	input logic [3:0] fixed_irq_src_i,
	input logic codec_irq_o
);
	// One clock domain, so clocking and reset are given once.
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	// A frame that ends while the port runs.
	sequence frame_on;
		frame_done_i && port_enable_bit_o;
	endsequence

	a_mode0_store: assert property (
		frame_on ##0 (!capture_mode_bit_o && aud_valid_i) |=> aud_rx_push_o)
		else $error("valid audio sample not stored");
	a_mode0_skip: assert property (
		frame_on ##0 (!capture_mode_bit_o && !tel_valid_i) |=> !tel_rx_push_o)
		else $error("telecom sample stored without valid");
	a_push_cause: assert property (
		aud_rx_push_o |-> $past(frame_done_i && port_enable_bit_o))
		else $error("audio store without a frame");
	a_push_data: assert property (
		aud_rx_push_o |-> aud_rx_data_o == $past(aud_data_i))
		else $error("stored audio data differs");
	a_enable_reset: assert property (
		$rose(rst_n_i) |-> !port_enable_bit_o)
		else $error("enable set after reset");
	a_irq_fixed: assert property (
		|fixed_irq_src_i |-> codec_irq_o)
		else $error("unmaskable source lost");
	a_pins_loop: assert property (
		pins_released_o && port_enable_bit_o
		|-> shifter_lsb_o == shifter_msb_i && !serial_out_pin_oe_o)
		else $error("loopback path wrong");
	a_pins_own: assert property (
		serial_out_pin_oe_o |-> !pins_released_o && port_enable_bit_o)
		else $error("pin driven while released");
	a_bresp_hold: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
endmodule

// *** sim/codec_link_model.sv ***
`timescale 1ns/1ps

module codec_link_model (
	input logic clk_i,
	input logic rst_n_i,
	input logic run_i,
	input logic all_valid_i,
	output logic sclk_o,
	output logic sdin_o,
	output logic frame_done_o,
	output logic valid_o,
	output logic [15:0] aud_o,
	output logic [15:0] tel_o
);
	logic [9:0] cnt_ff;
	logic [7:0] frm_ff;
	logic toggle_ff;

	// Frames of 128 serial clocks run back to back while enabled.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_ff <= 10'h0;
			frm_ff <= 8'h0;
			toggle_ff <= 1'b0;
		end else begin
			toggle_ff <= ~toggle_ff;
			cnt_ff <= run_i ? cnt_ff + 10'h1 : 10'h0;
			frm_ff <= !run_i ? 8'h0 : frm_ff + 8'(frame_done_o);
		end
	end

	// The skew keeps the link clock off the system clock edges.
	assign #37 sclk_o = run_i & cnt_ff[2];
	assign sdin_o = run_i ? cnt_ff[3] ^ frm_ff[0] : toggle_ff;
	assign frame_done_o = run_i && cnt_ff == 10'h3FF;
	// Held valid suits timer capture, sparse valid suits mode 0.
	assign valid_o = all_valid_i | frm_ff[0];
	assign aud_o = {8'hA5, frm_ff};
	assign tel_o = {8'h5A, frm_ff};
endmodule

// *** sim/tb_codec_port_control.sv ***
`timescale 1ns/1ps
`include "codec_port_consts.svh"

module tb_codec_port_control;
	import codec_port_pkg::*;
	logic clk_i, rst_n_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_rready, shifter_msb_i, all_valid;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rdat;
	logic [3:0] s_axi_wstrb, fixed_irq_src_i, fl;
	axi_resp_t s_axi_bresp, s_axi_rresp, rsp;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, serial_clock_pin_i, serial_in_pin_i;
	logic serial_out_pin_o, serial_out_pin_oe_o, pins_released_o;
	logic frame_done_i, aud_valid_i, tel_valid_i, shifter_lsb_o;
	logic aud_rx_push_o, tel_rx_push_o, port_enable_bit_o;
	logic capture_mode_bit_o, codec_irq_o, capture_irq_o;
	logic tel_tx_service_flag_i, tel_rx_service_flag_i;
	logic aud_tx_service_flag_i, aud_rx_service_flag_i;
	logic [15:0] aud_data_i, tel_data_i, aud_rx_data_o, tel_rx_data_o;
	logic [6:0] audio_rate_divisor_o, telecom_rate_divisor_o;
	int num_errors, n_checks, np_a, np_t, i;

	assign {aud_rx_service_flag_i, aud_tx_service_flag_i} = fl[3:2];
	assign {tel_rx_service_flag_i, tel_tx_service_flag_i} = fl[1:0];
	assign tel_valid_i = aud_valid_i;

	codec_port_control codec_port_control_inst (.*);

	codec_link_model codec_link_model_inst (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.run_i(port_enable_bit_o),
		.all_valid_i(all_valid),
		.sclk_o(serial_clock_pin_i),
		.sdin_o(serial_in_pin_i),
		.frame_done_o(frame_done_i),
		.valid_o(aud_valid_i),
		.aud_o(aud_data_i),
		.tel_o(tel_data_i)
	);

	// Stores are counted so that whole runs can be compared.
	always @(posedge clk_i) begin
		if (aud_rx_push_o === 1'b1) np_a++;
		if (tel_rx_push_o === 1'b1) np_t++;
	end

	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end

	task chk(input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			num_errors++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	// Address and data go out together and drop when each is taken.
	task wr(input logic [31:0] a, input logic [31:0] d);
		logic ta, tw, tk;
		@(posedge clk_i);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(negedge clk_i);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			tk = s_axi_bvalid && s_axi_bready;
			if (tk) rsp = s_axi_bresp;
			@(posedge clk_i);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			if (tk) s_axi_bready <= 1'b0;
		end while (!tk);
	endtask

	task rd(input logic [31:0] a);
		logic ta, tk;
		@(posedge clk_i);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(negedge clk_i);
			ta = s_axi_arvalid && s_axi_arready;
			tk = s_axi_rvalid && s_axi_rready;
			if (tk) rdat = s_axi_rdata;
			if (tk) rsp = s_axi_rresp;
			@(posedge clk_i);
			if (ta) s_axi_arvalid <= 1'b0;
			if (tk) s_axi_rready <= 1'b0;
		end while (!tk);
	endtask

	// Six frames with the port enabled, then the stores are compared.
	task cap(input logic [31:0] ctl, input logic vm, input int n);
		@(negedge clk_i);
		all_valid = vm;
		np_a = 0;
		np_t = 0;
		wr(`CPC_CTRL_ADDR, ctl);
		repeat (6) @(posedge frame_done_i);
		repeat (3) @(posedge clk_i);
		wr(`CPC_CTRL_ADDR, ctl & 32'hFFFE_FFFF);
		chk(np_a, n);
		chk(np_t, n);
	endtask

	task tally_and_finish;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial begin
		#4000000;
		num_errors++;
		tally_and_finish;
	end

	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready, shifter_msb_i} = 3'h0;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
		s_axi_wstrb = 4'hF;
		fixed_irq_src_i = 4'h0;
		fl = 4'h0;
		all_valid = 1'b0;
		rst_n_i = 1'b0;
		repeat (8) @(posedge clk_i);
		rst_n_i <= 1'b1;
		rd(`CPC_CTRL_ADDR);
		chk(32'(rdat[16]), 32'h0);
		wr(`CPC_CTRL_ADDR, 32'hFFFF_FFFF);
		chk(32'({audio_rate_divisor_o, telecom_rate_divisor_o}), 32'h3FFF);
		rd(`CPC_CTRL_ADDR);
		chk(rdat, `CPC_CTRL_WMASK);
		wr(`CPC_CTRL_ADDR, 32'h0);
		rd(32'h8000_2020);
		chk({rdat[31:2], rsp}, {30'h0, RESP_SLVERR});
		// Each flag reaches the line with its own mask set and is blocked with all masks clear.
		for (i = 0; i < 4; i++) begin
			@(posedge clk_i);
			fl <= 4'(1 << i);
			wr(`CPC_CTRL_ADDR, 32'h1 << (19 + i));
			@(negedge clk_i);
			chk(32'(codec_irq_o), 32'h1);
			wr(`CPC_CTRL_ADDR, 32'h0);
			@(negedge clk_i);
			chk(32'(codec_irq_o), 32'h0);
			rd(`CPC_FLAG_STAT_ADDR);
			chk(rdat & 32'hF, 32'h1 << i);
		end
		fl <= 4'h0;
		fixed_irq_src_i <= 4'h8;
		@(negedge clk_i);
		chk(32'(codec_irq_o), 32'h1);
		@(posedge clk_i);
		fixed_irq_src_i <= 4'h0;
		cap(32'h0001_0707, 1'b0, 3);
		cap(32'h0005_0707, 1'b1, 4);
		// The last store of both channels came from the sixth frame.
		chk({aud_rx_data_o, tel_rx_data_o}, 32'hA505_5A05);
		rd(`CPC_EVT_STAT_ADDR);
		chk(rdat, 32'hF);
		wr(`CPC_EVT_EN_ADDR, 32'h1);
		@(negedge clk_i);
		chk(32'(capture_irq_o), 32'h1);
		wr(`CPC_EVT_EN_ADDR, 32'h0);
		@(negedge clk_i);
		chk(32'(capture_irq_o), 32'h0);
		wr(`CPC_EVT_EN_ADDR, 32'h1);
		wr(`CPC_EVT_CLR_ADDR, 32'h1);
		rd(`CPC_EVT_STAT_ADDR);
		chk(rdat, 32'hE);
		chk(32'(capture_irq_o), 32'h0);
		// Loopback releases the pins and closes the shifter on itself.
		wr(`CPC_CTRL_ADDR, 32'h0081_0000);
		shifter_msb_i <= 1'b1;
		@(negedge clk_i);
		chk({pins_released_o, serial_out_pin_oe_o, shifter_lsb_o}, 3'h5);
		wr(`CPC_CTRL_ADDR, 32'h0001_0000);
		@(negedge clk_i);
		chk({pins_released_o, serial_out_pin_oe_o, serial_out_pin_o}, 3'h3);
		wr(`CPC_CTRL_ADDR, 32'h0);
		tally_and_finish;
	end
endmodule

bind codec_port_control codec_port_properties #(.DATA_W(DATA_W)) props_inst (
	.clk_i, .rst_n_i, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
	.frame_done_i, .aud_valid_i, .tel_valid_i, .aud_data_i,
	.port_enable_bit_o, .capture_mode_bit_o, .aud_rx_push_o,
	.tel_rx_push_o, .aud_rx_data_o, .serial_out_pin_oe_o,
	.pins_released_o, .shifter_msb_i, .shifter_lsb_o,
	.fixed_irq_src_i, .codec_irq_o
);
